/* design/relay_mode_pkg.sv */
// constants, types and field layout of the relay driver mode and reset controller
package relay_mode_pkg;

  // ********************
  // timing
  // ********************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int WAKEUP_TIME_US = 200;
  localparam int WAKEUP_CYCLES = WAKEUP_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam int UV_DELAY_US = 1;
  localparam int UV_DELAY_CYCLES = UV_DELAY_US * 1000000 / CLK_PERIOD_PS;
  localparam int SYNC_STAGES = 2;

  // ********************
  // register port map
  // ********************
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_CHAN = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_DIAG = 4'hC;
  localparam int CMD_WAKE_BIT = 0;
  localparam int STANDBY_COMMAND_BIT_BIT = 1;
  localparam int CMD_RST_BIT = 2;

  // ********************
  // serial frame layout
  // ********************
  localparam int FRAME_BITS = 16;
  localparam int FRAME_WR_BIT = 15;
  localparam int FRAME_ADDR_HI = 14;
  localparam int FRAME_ADDR_LO = 12;
  localparam logic [2:0] FRAME_ADDR_CMD = 3'h0;
  localparam logic [2:0] FRAME_ADDR_CHAN = 3'h1;
  localparam logic [5:0] BIT_CNT_MAX = 6'h3F;

  // ********************
  // channels and reset values
  // ********************
  localparam int NUM_CH = 8;
  localparam int LIMP_CH_A = 4;
  localparam int LIMP_CH_B = 5;
  localparam logic [7:0] CHAN_RESET = 8'h00;
  localparam logic [7:0] DIAG_RESET = 8'h00;
  localparam logic TER_RESET = 1'b1;

  typedef enum logic [2:0] {
    MODE_SLEEP = 3'b001,
    MODE_ACTIVE = 3'b010,
    MODE_LIMP = 3'b100
  } mode_t;

  typedef struct packed {
    logic wake;
    logic standby;
    logic reset;
  } cmd_t;

endpackage

/* design/relay_mode_ctrl.sv */
// mode sequencing, reset sources, serial shift register and channel gating of the relay driver
//
// Chosen here: the address map and the plain strobed port.
module relay_mode_ctrl
  import relay_mode_pkg::*;
#(
  parameter int WAKEUP_CYCLES_P = WAKEUP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic batteryOkIn,
  input wire logic logicOkIn,
  input wire logic failSafePin,
  input wire logic [1:0] inPin,
  input wire logic spiCsN,
  input wire logic spiSclk,
  input wire logic spiSi,
  output logic spiSo,
  output logic spiSoOeN,
  input wire logic [7:0] diagFlags,
  output logic [7:0] channelOn,
  output logic diagEnable,
  output mode_t modeOut,
  output logic frameError
);

  localparam int CNT_W = $clog2(WAKEUP_CYCLES_P + 1);
  localparam logic [CNT_W-1:0] WAKE_LOAD = CNT_W'(WAKEUP_CYCLES_P);

  // ********************
  // helpers
  // ********************
  function automatic cmd_t cmdDecode(input logic [7:0] data);
    cmd_t c;
    c.wake = data[CMD_WAKE_BIT];
    c.standby = data[STANDBY_COMMAND_BIT_BIT];
    c.reset = data[CMD_RST_BIT];
    return c;
  endfunction

  function automatic logic riseOf(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  // ********************
  // input synchronisers
  // ********************
  // packing: batteryOk, logicOk, failSafe, in[1:0], csN, sclk, si
  localparam logic [7:0] SYNC_RESET = 8'h04;
  logic [7:0] rawIn;
  logic [7:0] sync1Reg;
  logic [7:0] sync2Reg;
  logic [1:0] edgeReg;

  assign rawIn = {batteryOkIn, logicOkIn, failSafePin, inPin, spiCsN, spiSclk, spiSi};

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1Reg <= SYNC_RESET;
      sync2Reg <= SYNC_RESET;
      edgeReg <= 2'b10;
    end else if (ce) begin
      sync1Reg <= rawIn;
      sync2Reg <= sync1Reg;
      edgeReg <= sync2Reg[2:1];
    end
  end

  wire batOk = sync2Reg[7];
  wire logOk = sync2Reg[6];
  wire failSafe = sync2Reg[5];
  wire [1:0] inSync = sync2Reg[4:3];
  wire csN = sync2Reg[2];
  wire sclk = sync2Reg[1];
  wire si = sync2Reg[0];
  wire csFall = riseOf(edgeReg[1], csN);
  wire csRise = riseOf(csN, edgeReg[1]);
  wire sclkRise = riseOf(sclk, edgeReg[0]);
  wire sclkFall = riseOf(edgeReg[0], sclk);

  // ********************
  // state
  // ********************
  mode_t modeReg;
  mode_t modeNext;
  logic [7:0] chanReg;
  logic [7:0] chanNext;
  logic [7:0] diagReg;
  logic [7:0] diagNext;
  logic terReg;
  logic [CNT_W-1:0] wakeCntReg;
  logic [CNT_W-1:0] wakeCntNext;
  logic [7:0] chanOnNext;
  logic [FRAME_BITS-1:0] shiftReg;
  logic [5:0] bitCntReg;
  logic soReg;
  logic soOeNReg;
  logic [7:0] rdataNext;

  // ********************
  // reset sources
  // ********************
  wire uvReset = ~batOk | ~logOk;
  wire waking = wakeCntReg != '0;
  wire inLimp = modeReg == MODE_LIMP;
  wire limpEntry = failSafe & ~inLimp;
  wire cmdAllowed = ~uvReset & ~failSafe;

  // ********************
  // serial frame decode
  // ********************
  wire frameDone = csRise & logOk & (bitCntReg >= 6'(FRAME_BITS));
  wire frameKept = frameDone & ~waking;
  wire spiWr = frameKept & shiftReg[FRAME_WR_BIT] & cmdAllowed;
  wire [2:0] frameAddr = shiftReg[FRAME_ADDR_HI:FRAME_ADDR_LO];
  wire spiCmdHit = spiWr & (frameAddr == FRAME_ADDR_CMD);
  wire spiChanHit = spiWr & (frameAddr == FRAME_ADDR_CHAN);
  wire [FRAME_BITS-1:0] statusFrame = {terReg, failSafe, modeReg, 3'h0, diagReg};

  // ********************
  // register port decode
  // ********************
  wire busWr = regWr & cmdAllowed;
  wire busCmdHit = busWr & (regAddr == ADDR_CMD);
  wire busChanHit = busWr & (regAddr == ADDR_CHAN);
  wire cmd_t busCmd = busCmdHit ? cmdDecode(regWdata) : '0;
  wire cmd_t spiCmd = spiCmdHit ? cmdDecode(shiftReg[7:0]) : '0;
  wire cmd_t cmd = busCmd | spiCmd;

  // ********************
  // mode sequencing
  // ********************
  always_comb begin
    modeNext = modeReg;
    if (uvReset) begin
      modeNext = MODE_SLEEP;
    end else if (failSafe) begin
      modeNext = MODE_LIMP;
    end else begin
      case (modeReg)
        MODE_SLEEP: begin
          if (cmd.wake && !cmd.reset) begin
            modeNext = MODE_ACTIVE;
          end
        end
        MODE_ACTIVE: begin
          if (cmd.standby || cmd.reset) begin
            modeNext = MODE_SLEEP;
          end
        end
        MODE_LIMP: begin
          modeNext = MODE_SLEEP;
        end
        default: begin
          modeNext = MODE_SLEEP;
        end
      endcase
    end
  end

  wire enterSleep = (modeNext == MODE_SLEEP) & (modeReg != MODE_SLEEP);
  wire anyReset = uvReset | cmd.reset | limpEntry;
  // banks held in reset without battery or with fail-safe high
  wire regClear = anyReset | failSafe | ~batOk | enterSleep;

  // ********************
  // register banks
  // ********************
  always_comb begin
    chanNext = chanReg;
    if (regClear) begin
      chanNext = CHAN_RESET;
    end else if (modeReg == MODE_ACTIVE) begin
      if (spiChanHit) begin
        chanNext = shiftReg[7:0];
      end else if (busChanHit) begin
        chanNext = regWdata;
      end
    end
  end

  always_comb begin
    diagNext = diagReg;
    if (regClear) begin
      diagNext = DIAG_RESET;
    end else if (diagEnable) begin
      diagNext = diagReg | diagFlags;
    end
  end

  always_comb begin
    wakeCntNext = wakeCntReg;
    if (modeNext != MODE_ACTIVE) begin
      wakeCntNext = '0;
    end else if (modeReg == MODE_SLEEP) begin
      wakeCntNext = WAKE_LOAD;
    end else if (waking) begin
      wakeCntNext = wakeCntReg - CNT_W'(1);
    end
  end

  // ********************
  // channel drive
  // ********************
  always_comb begin
    chanOnNext = '0;
    if (anyReset || !batOk) begin
      chanOnNext = '0;
    end else if (modeReg == MODE_ACTIVE) begin
      chanOnNext = chanReg;
    end else if (inLimp) begin
      chanOnNext[LIMP_CH_A] = inSync[0];
      chanOnNext[LIMP_CH_B] = inSync[1];
    end
  end

  wire diagEnNext = batOk & ~failSafe & ~uvReset;

  always_ff @(posedge clk) begin
    if (rst) begin
      modeReg <= MODE_SLEEP;
      chanReg <= CHAN_RESET;
      diagReg <= DIAG_RESET;
      terReg <= TER_RESET;
      wakeCntReg <= '0;
      channelOn <= '0;
      diagEnable <= 1'b0;
    end else if (ce) begin
      modeReg <= modeNext;
      chanReg <= chanNext;
      diagReg <= diagNext;
      // setting wins over the clear by a finished frame
      terReg <= anyReset | (terReg & ~frameKept);
      wakeCntReg <= wakeCntNext;
      channelOn <= chanOnNext;
      diagEnable <= diagEnNext;
    end
  end

  // ********************
  // serial shift register
  // ********************
  // runs on logic supply alone; battery state never gates it
  always_ff @(posedge clk) begin
    if (rst) begin
      shiftReg <= '0;
      bitCntReg <= '0;
      soReg <= 1'b0;
      soOeNReg <= 1'b1;
    end else if (ce) begin
      if (!logOk) begin
        bitCntReg <= '0;
        soOeNReg <= 1'b1;
      end else if (csFall) begin
        shiftReg <= statusFrame;
        bitCntReg <= '0;
        soReg <= statusFrame[FRAME_BITS-1];
        soOeNReg <= 1'b0;
      end else if (csRise) begin
        soOeNReg <= 1'b1;
      end else if (!csN && sclkRise) begin
        shiftReg <= {shiftReg[FRAME_BITS-2:0], si};
        if (bitCntReg != BIT_CNT_MAX) begin
          bitCntReg <= bitCntReg + 6'h01;
        end
      end else if (!csN && sclkFall) begin
        soReg <= shiftReg[FRAME_BITS-1];
      end
    end
  end

  // ********************
  // register port read
  // ********************
  wire [7:0] statusWord = {terReg, failSafe, diagEnable, waking, logOk, modeReg};

  always_comb begin
    rdataNext = 8'h00;
    if (regRd) begin
      case (regAddr)
        ADDR_CHAN: rdataNext = chanReg;
        ADDR_STATUS: rdataNext = statusWord;
        ADDR_DIAG: rdataNext = diagReg;
        default: rdataNext = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= 8'h00;
      modeOut <= MODE_SLEEP;
      frameError <= TER_RESET;
      spiSo <= 1'b0;
      spiSoOeN <= 1'b1;
    end else if (ce) begin
      regRdata <= rdataNext;
      modeOut <= modeReg;
      frameError <= terReg;
      spiSo <= soReg;
      spiSoOeN <= soOeNReg;
    end
  end

endmodule

/* bench/relay_mode_ctrl_asserts.sv */
// port checker of the relay mode controller
module relay_mode_ctrl_asserts
  import relay_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic batteryOkIn,
  input wire logic logicOkIn,
  input wire logic failSafePin,
  input wire logic [1:0] inPin,
  input wire logic spiSoOeN,
  input wire logic [7:0] channelOn,
  input wire logic diagEnable,
  input wire mode_t modeOut,
  input wire logic frameError
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // **********
  // cycles of good supplies, pin low
  // **********
  logic [2:0] okCnt;
  wire logic good = batteryOkIn & logicOkIn & ~failSafePin;
  wire logic cmdWr = okCnt == 3'h7 && regWr && regAddr == ADDR_CMD;
  wire logic fsOk = failSafePin && batteryOkIn && logicOkIn;
  always_ff @(posedge clk) begin
    if (rst || !good) okCnt <= 3'h0;
    else if (okCnt != 3'h7) okCnt <= okCnt + 3'h1;
  end
  property p_uv; (!batteryOkIn)[*5] |-> channelOn == 8'h00 && frameError && modeOut == MODE_SLEEP; endproperty
  a_uv: assert property (p_uv) else $error("uv reset missing");
  property p_uvHold; (!logicOkIn)[*5] |-> modeOut == MODE_SLEEP && spiSoOeN; endproperty
  a_uvHold: assert property (p_uvHold) else $error("logic uv not held");
  property p_limp; fsOk[*8] |-> modeOut == MODE_LIMP && !diagEnable; endproperty
  a_limp: assert property (p_limp) else $error("no limp");
  property p_limpCh; (fsOk && inPin == 2'b01)[*8] |-> channelOn == 8'h10; endproperty
  a_limpCh: assert property (p_limpCh) else $error("limp channels");
  property p_exit; $fell(modeOut == MODE_LIMP) |-> modeOut == MODE_SLEEP; endproperty
  a_exit: assert property (p_exit) else $error("limp exit");
  property p_wake; cmdWr && regWdata == 8'h01 && modeOut == MODE_SLEEP |-> ##2 modeOut == MODE_ACTIVE; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_stb; cmdWr && regWdata == 8'h02 && modeOut == MODE_ACTIVE |-> ##2 modeOut == MODE_SLEEP && channelOn == 8'h00;
  endproperty
  a_stb: assert property (p_stb) else $error("no standby");
  property p_rst; cmdWr && regWdata[2] |-> ##2 frameError && channelOn == 8'h00 && modeOut == MODE_SLEEP; endproperty
  a_rst: assert property (p_rst) else $error("reset cmd");
endmodule
bind relay_mode_ctrl relay_mode_ctrl_asserts i_relay_mode_ctrl_asserts (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .batteryOkIn(batteryOkIn), .logicOkIn(logicOkIn), .failSafePin(failSafePin),
  .inPin(inPin), .spiSoOeN(spiSoOeN), .channelOn(channelOn), .diagEnable(diagEnable), .modeOut(modeOut),
  .frameError(frameError));

/* bench/spi_host.sv */
// host serial master model, 160 ns link clock
module spi_host (
  output logic csN,
  output logic sclk,
  output logic si,
  input wire logic so,
  input wire logic soOeN
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lastSo = 1'b0;
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // sclk idles low; released output reads as the inverse of the last bit seen
  task automatic xfer(input logic [15:0] tx, input int gap, output logic [15:0] rx);
    csN = 1'b0;
    #(gap);
    for (int i = 15; i >= 0; i--) begin
      si = tx[i];
      #80 sclk = 1'b1;
      rx[i] = (soOeN === 1'b0) ? so : ~lastSo;
      lastSo = rx[i];
      #80 sclk = 1'b0;
    end
    #(gap) csN = 1'b1;
    si = ~si;
  endtask
endmodule

/* bench/tb.sv */
// self-checking bench of the relay mode controller
module tb
  import relay_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, failSafePin = 1'b0;
  logic batteryOkIn = 1'b1, logicOkIn = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, diagFlags = 8'h00, regRdata, channelOn, rd;
  logic [1:0] inPin = 2'h0;
  logic spiCsN, spiSclk, spiSi, spiSo, spiSoOeN, diagEnable, frameError;
  logic [15:0] rx;
  mode_t modeOut;
  int err_total = 0, comparisons = 0;
  localparam int WAKE_SIM = 1000;
  always #2 clk = ~clk;
  relay_mode_ctrl #(.WAKEUP_CYCLES_P(WAKE_SIM)) i_relay_mode_ctrl (.clk(clk), .rst(rst), .ce(1'b1), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .batteryOkIn(batteryOkIn),
    .logicOkIn(logicOkIn), .failSafePin(failSafePin), .inPin(inPin), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .spiSi(spiSi), .spiSo(spiSo), .spiSoOeN(spiSoOeN), .diagFlags(diagFlags), .channelOn(channelOn),
    .diagEnable(diagEnable), .modeOut(modeOut), .frameError(frameError));
  spi_host i_spi_host (.csN(spiCsN), .sclk(spiSclk), .si(spiSi), .so(spiSo), .soOeN(spiSoOeN));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wake;
    wr(ADDR_CMD, 8'h01);
    cyc(WAKE_SIM + 5);
  endtask
  task automatic t_reset;
    chk({frameError, modeOut, channelOn}, {1'b1, MODE_SLEEP, 8'h00});
    rdr(ADDR_STATUS);
    chk(rd & 8'h8F, 8'h89);
    rdr(4'h6);
    chk(rd, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_active;
    wake();
    chk(modeOut, MODE_ACTIVE);
    wr(ADDR_CHAN, 8'hA5);
    cyc(3);
    chk(channelOn, 8'hA5);
    i_spi_host.xfer(16'h0000, 40, rx);
    chk(rx, 16'h9000);
    wr(ADDR_CMD, 8'h02);
    cyc(3);
    chk({modeOut, channelOn}, {MODE_SLEEP, 8'h00});
    wake();
    rdr(ADDR_CHAN);
    chk(rd, 8'h00);
    $display("test active done");
  endtask
  task automatic t_spi;
    wr(ADDR_CMD, 8'h02);
    i_spi_host.xfer(16'h8001, 400, rx);
    cyc(4);
    i_spi_host.xfer(16'h903C, 40, rx);
    cyc(6);
    chk(channelOn, 8'h00);
    cyc(WAKE_SIM);
    chk(modeOut, MODE_ACTIVE);
    i_spi_host.xfer(16'h903C, 400, rx);
    cyc(6);
    chk(channelOn, 8'h3C);
    @(posedge clk) diagFlags <= 8'h81;
    @(posedge clk) diagFlags <= 8'h00;
    rdr(ADDR_DIAG);
    chk(rd, 8'h81);
    wr(ADDR_CMD, 8'h04);
    cyc(3);
    chk({frameError, modeOut, channelOn}, {1'b1, MODE_SLEEP, 8'h00});
    rdr(ADDR_DIAG);
    chk(rd, 8'h00);
    $display("test serial done");
  endtask
  task automatic t_limp;
    @(posedge clk) failSafePin <= 1'b1;
    cyc(8);
    chk(modeOut, MODE_LIMP);
    @(posedge clk) failSafePin <= 1'b0;
    cyc(8);
    wake();
    wr(ADDR_CHAN, 8'hFF);
    failSafePin <= 1'b1;
    inPin <= 2'b10;
    cyc(8);
    chk({modeOut, channelOn}, {MODE_LIMP, 8'h20});
    chk({diagEnable, frameError}, 2'b01);
    wr(ADDR_CHAN, 8'hFF);
    inPin <= 2'b01;
    cyc(6);
    chk(channelOn, 8'h10);
    i_spi_host.xfer(16'h8001, 40, rx);
    chk(rx[14:11], 4'hC);
    @(posedge clk) failSafePin <= 1'b0;
    cyc(6);
    chk({modeOut, channelOn}, {MODE_SLEEP, 8'h00});
    $display("test limp done");
  endtask
  task automatic t_uv;
    wake();
    wr(ADDR_CHAN, 8'h0F);
    batteryOkIn <= 1'b0;
    cyc(250);
    chk({frameError, modeOut, channelOn}, {1'b1, MODE_SLEEP, 8'h00});
    i_spi_host.xfer(16'h0000, 40, rx);
    chk(rx[15], 1'b1);
    @(posedge clk) batteryOkIn <= 1'b1;
    logicOkIn <= 1'b0;
    cyc(6);
    i_spi_host.xfer(16'h0000, 40, rx);
    chk(rx, 16'hAAAA);
    chk(spiSoOeN, 1'b1);
    wr(ADDR_CMD, 8'h01);
    cyc(3);
    chk(modeOut, MODE_SLEEP);
    @(posedge clk) logicOkIn <= 1'b1;
    cyc(8);
    wake();
    chk(modeOut, MODE_ACTIVE);
    $display("test undervoltage done");
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cyc(8);
    t_reset();
    t_active();
    t_spi();
    t_limp();
    t_uv();
    end_sim();
  end
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule
